// >>> lcfm_cfg.svh
`ifndef LCFM_CFG_SVH
`define LCFM_CFG_SVH
// Number of LED channels.
`define LCFM_NUM_CH 4
// Dimming PWM periods before a faulty channel is cut off.
`define LCFM_TIMEOUT_PERIODS 3'h6
// Start-up short window in microseconds and its cycle count at 50 MHz.
`define LCFM_SHORT_WINDOW_US 31000
`define LCFM_CLK_MHZ 50
`define LCFM_SHORT_WINDOW_CYC (`LCFM_SHORT_WINDOW_US * `LCFM_CLK_MHZ)
// Current scale codes in percent of set current.
`define LCFM_SCALE_FULL 7'h64
`define LCFM_SCALE_FIRST 7'h4c
`define LCFM_SCALE_STEP 7'h08
`define LCFM_SCALE_FLOOR 7'h0c
`endif

// >>> lcfm_pkg.sv
package lcfm_pkg;
  // Per-channel sense flags from the analog comparators.
  typedef struct packed {
    logic [3:0] fbOverShort;
    logic [3:0] belowTarget;
  } lcfm_chsense_t;
  // Global sense flags.
  typedef struct packed {
    logic otpLower;
    logic otpUpper;
    logic ovpOver;
    logic ovpBelow20;
    logic startShort;
  } lcfm_gsense_t;
  typedef enum logic [3:0] {
    ST_STARTUP = 4'h1,
    ST_RUN = 4'h2,
    ST_HOT = 4'h4,
    ST_DEAD = 4'h8
  } lcfm_state_t;
endpackage

// >>> lcfm_chan_timer.sv
`timescale 1ns/1ps
`include "lcfm_cfg.svh"
module lcfm_chan_timer (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Fault timing
  input wire logic pwmTick,
  input wire logic faultCond,
  output logic chanOff
);
  logic [2:0] cnt_q;

  // The counter only advances on dimming period boundaries.
  always_ff @(posedge clk)
  begin
    if (sys_rst || chanOff)
      cnt_q <= 3'h0;
    else if (!faultCond)
      cnt_q <= 3'h0;
    else if (pwmTick)
      cnt_q <= cnt_q + 3'h1;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      chanOff <= 1'b0;
    else if (faultCond && pwmTick && cnt_q == `LCFM_TIMEOUT_PERIODS - 3'h1)
      chanOff <= 1'b1;
  end

  a_cnt_clears: assert property (@(posedge clk) disable iff (sys_rst)
    !faultCond && !chanOff |=> cnt_q == 3'h0) else $error("timeout count not cleared");
  a_no_early_off: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(chanOff) |-> $past(cnt_q) == 3'h5) else $error("channel cut off early");
endmodule // lcfm_chan_timer

// >>> lcfm_fault_mgr.sv
`timescale 1ns/1ps
`include "lcfm_cfg.svh"
// What this block does
// - Channel feedback above 4V, upper limit not tripped: cut after six periods.
// - Lower over-temperature: channels below target fault out after six periods.
// - Upper over-temperature: all off until cool, then 76%, 8% lower each trip down to a floor of 12%.
// - Overvoltage: channels below target time out after six periods.
// - Output or switch node shorted: permanent shutdown 31ms after power-up.
// - Overvoltage sense dropping below 20% in operation counts as short.
// - Sense rising then falling below 20% opens the input protection switch.
// - Channel good at target; later drop below target means open, timed out.
module lcfm_fault_mgr #(
  parameter int SHORT_WINDOW_CYC = `LCFM_SHORT_WINDOW_CYC
) (
  // Clock and reset; reset also stands for undervoltage lockout
  input wire logic clk,
  input wire logic sys_rst,
  // Sense inputs
  input wire logic pwmPeriodStart,
  input wire lcfm_pkg::lcfm_chsense_t chSense,
  input wire lcfm_pkg::lcfm_gsense_t gSense,
  // Controls
  output logic [3:0] chanEnable,
  output logic [6:0] currentScale,
  output logic boostEnable,
  output logic inputSwitchOn,
  output logic shutdownLatched
);
  lcfm_pkg::lcfm_state_t state_q;
  logic [3:0] good_q;
  logic [3:0] chanOff;
  logic [3:0] faultCond;
  logic [25:0] upTime_q;
  logic ovpSeenHigh_q;
  logic windowDone;
  logic outShort;

  assign windowDone = upTime_q >= 26'(SHORT_WINDOW_CYC);
  // A short at start-up is only acted on once the window has elapsed.
  assign outShort = (gSense.startShort && windowDone) || (state_q == lcfm_pkg::ST_RUN && gSense.ovpBelow20);

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      upTime_q <= 26'h0;
    else if (!windowDone)
      upTime_q <= upTime_q + 26'h1;
  end

  // Good once at target; never cleared until reset.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      good_q <= 4'h0;
    else
      good_q <= good_q | ~chSense.belowTarget;
  end

  always_comb
  begin
    for (int i = 0; i < `LCFM_NUM_CH; i++)
      faultCond[i] = (!gSense.otpUpper && chSense.fbOverShort[i])
        || (chSense.belowTarget[i] && (good_q[i] || gSense.otpLower || gSense.ovpOver));
  end

  for (genvar g = 0; g < `LCFM_NUM_CH; g++)
  begin : gChan
    lcfm_chan_timer lcfm_chan_timer_i (
      .clk(clk),
      .sys_rst(sys_rst),
      .pwmTick(pwmPeriodStart),
      .faultCond(faultCond[g]),
      .chanOff(chanOff[g])
    );
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      state_q <= lcfm_pkg::ST_STARTUP;
    else
    begin
      case (state_q)
        lcfm_pkg::ST_STARTUP:
          if (outShort)
            state_q <= lcfm_pkg::ST_DEAD;
          else if (windowDone)
            state_q <= lcfm_pkg::ST_RUN;
        lcfm_pkg::ST_RUN:
          if (outShort)
            state_q <= lcfm_pkg::ST_DEAD;
          else if (gSense.otpUpper)
            state_q <= lcfm_pkg::ST_HOT;
        lcfm_pkg::ST_HOT:
          if (!gSense.otpUpper)
            state_q <= lcfm_pkg::ST_RUN;
        lcfm_pkg::ST_DEAD:
          state_q <= lcfm_pkg::ST_DEAD;
        default:
          state_q <= lcfm_pkg::ST_DEAD;
      endcase
    end
  end

  // The scale steps down once per trip and stops at a floor so the current scale never drops to zero.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      currentScale <= `LCFM_SCALE_FULL;
    else if (state_q == lcfm_pkg::ST_RUN && gSense.otpUpper && !outShort)
    begin
      if (currentScale == `LCFM_SCALE_FULL)
        currentScale <= `LCFM_SCALE_FIRST;
      else if (currentScale > `LCFM_SCALE_FLOOR)
        currentScale <= currentScale - `LCFM_SCALE_STEP;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      ovpSeenHigh_q <= 1'b0;
    else if (!gSense.ovpBelow20)
      ovpSeenHigh_q <= 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      inputSwitchOn <= 1'b1;
    else if ((ovpSeenHigh_q && gSense.ovpBelow20) || state_q == lcfm_pkg::ST_DEAD)
      inputSwitchOn <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      chanEnable <= 4'h0;
      boostEnable <= 1'b0;
      shutdownLatched <= 1'b0;
    end
    else
    begin
      chanEnable <= (state_q == lcfm_pkg::ST_RUN) ? ~chanOff : 4'h0;
      boostEnable <= state_q == lcfm_pkg::ST_RUN;
      shutdownLatched <= state_q == lcfm_pkg::ST_DEAD;
    end
  end

  a_dead_sticks: assert property (@(posedge clk) disable iff (sys_rst)
    state_q == lcfm_pkg::ST_DEAD |=> state_q == lcfm_pkg::ST_DEAD) else $error("shutdown left");
  a_short_early: assert property (@(posedge clk) disable iff (sys_rst)
    !windowDone && !gSense.ovpBelow20 |=> state_q != lcfm_pkg::ST_DEAD) else $error("early shutdown");
  a_hot_all_off: assert property (@(posedge clk) disable iff (sys_rst)
    state_q == lcfm_pkg::ST_HOT |=> chanEnable == 4'h0 && !boostEnable) else $error("channels on while hot");
  a_first_trip: assert property (@(posedge clk) disable iff (sys_rst)
    state_q == lcfm_pkg::ST_RUN && gSense.otpUpper && !outShort && currentScale == `LCFM_SCALE_FULL
    |=> currentScale == `LCFM_SCALE_FIRST) else $error("first trip scale wrong");
  a_run_short: assert property (@(posedge clk) disable iff (sys_rst)
    state_q == lcfm_pkg::ST_RUN && gSense.ovpBelow20 |=> state_q == lcfm_pkg::ST_DEAD) else $error("short missed");
  a_protect_off: assert property (@(posedge clk) disable iff (sys_rst)
    ovpSeenHigh_q && gSense.ovpBelow20 |=> !inputSwitchOn) else $error("input switch stayed on");
  a_open_fault: assert property (@(posedge clk) disable iff (sys_rst)
    good_q[0] && chSense.belowTarget[0] |-> faultCond[0]) else $error("open channel not timed");
  a_lower_otp: assert property (@(posedge clk) disable iff (sys_rst)
    gSense.otpLower && chSense.belowTarget[1] |-> faultCond[1]) else $error("lower trip ignored");
  a_ovp_fault: assert property (@(posedge clk) disable iff (sys_rst)
    gSense.ovpOver && chSense.belowTarget[2] |-> faultCond[2]) else $error("overvoltage ignored");
  a_short_fb: assert property (@(posedge clk) disable iff (sys_rst)
    !gSense.otpUpper && chSense.fbOverShort[3] |-> faultCond[3]) else $error("short fb ignored");

  c_hot: cover property (@(posedge clk) state_q == lcfm_pkg::ST_HOT);
  c_dead: cover property (@(posedge clk) state_q == lcfm_pkg::ST_DEAD);
  c_chan_off: cover property (@(posedge clk) chanOff != 4'h0);
  c_second_trip: cover property (@(posedge clk) currentScale < `LCFM_SCALE_FIRST);
endmodule // lcfm_fault_mgr

// >>> lcfm_sense_model.sv
`timescale 1ns/1ps
module lcfm_sense_model (
  // Clock
  input wire logic clk,
  // Levels the bench asks the comparators to show
  input wire logic [3:0] wantFb,
  input wire logic [3:0] wantLow,
  input wire logic [4:0] wantG,
  // Comparator and dimming outputs
  output logic pwmPeriodStart,
  output lcfm_pkg::lcfm_chsense_t chSense,
  output lcfm_pkg::lcfm_gsense_t gSense
);
  // The period counter free-runs from time zero so the pulse is never unknown.
  logic [3:0] divQ = 4'h0;
  always @(posedge clk)
  begin
    divQ <= (divQ == 4'h9) ? 4'h0 : divQ + 4'h1;
  end
  assign pwmPeriodStart = divQ == 4'h9;
  assign chSense = {wantFb, wantLow};
  assign gSense = wantG;
endmodule // lcfm_sense_model

// >>> tb_lcfm_fault_mgr.sv
`timescale 1ns/1ps
module tb_lcfm_fault_mgr;
  localparam int WIN = 20;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [3:0] wantFb = 4'h0;
  logic [3:0] wantLow = 4'h0;
  logic [4:0] wantG = 5'h00;
  logic pwmPeriodStart;
  lcfm_pkg::lcfm_chsense_t chSense;
  lcfm_pkg::lcfm_gsense_t gSense;
  logic [3:0] chanEnable;
  logic [6:0] currentScale;
  logic boostEnable;
  logic inputSwitchOn;
  logic shutdownLatched;
  int n_mismatch = 0;
  int cmp_count = 0;
  int cycles = 0;
  int seed = 32'h5949c1a1;
  int base;
  int ch;
  logic [6:0] expMask;
  initial
  begin
    forever #10 clk = ~clk;
  end
  lcfm_sense_model lcfm_sense_model_i (.clk, .wantFb, .wantLow, .wantG, .pwmPeriodStart, .chSense, .gSense);
  lcfm_fault_mgr #(.SHORT_WINDOW_CYC(WIN)) lcfm_fault_mgr_i (.clk, .sys_rst, .pwmPeriodStart, .chSense,
    .gSense, .chanEnable, .currentScale, .boostEnable, .inputSwitchOn, .shutdownLatched);
  task automatic chk(input string nm, input logic [6:0] e, input logic [6:0] g);
    cmp_count++;
    if (g !== e)
    begin
      $display("BAD %s exp %h got %h", nm, e, g);
      n_mismatch++;
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic pulses(input int n);
    repeat (n) @(posedge clk iff pwmPeriodStart);
  endtask
  // Fault held for exactly five periods must leave the channel on; the sixth cuts it.
  task automatic cut_after_six();
    pulses(5);
    cyc(4);
    @(negedge clk);
    chk("chanEnable", expMask, {3'h0, chanEnable});
    pulses(1);
    cyc(4);
    expMask[ch] = 1'b0;
    @(negedge clk);
    chk("chanEnable", expMask, {3'h0, chanEnable});
    cyc(1);
  endtask
  task automatic chk_reset();
    @(negedge clk);
    chk("chanEnable", 7'h00, {3'h0, chanEnable});
    chk("boostEnable", 7'h00, {6'h00, boostEnable});
    chk("currentScale", 7'h64, currentScale);
    chk("inputSwitchOn", 7'h01, {6'h00, inputSwitchOn});
    chk("shutdownLatched", 7'h00, {6'h00, shutdownLatched});
    $display("reset test done");
  endtask
  task automatic finish_test();
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      n_mismatch++;
      finish_test();
    end
  end
  initial
  begin
    base = $random(seed) & 3;
    cyc(3);
    chk_reset();
    cyc(1);
    sys_rst <= 1'b0;
    cyc(WIN / 2);
    @(negedge clk);
    chk("boostEnable", 7'h00, {6'h00, boostEnable});
    cyc(WIN);
    @(negedge clk);
    expMask = 7'h0f;
    chk("chanEnable", expMask, {3'h0, chanEnable});
    chk("boostEnable", 7'h01, {6'h00, boostEnable});
    ch = base;
    pulses(1);
    wantFb[ch] <= 1'b1;
    pulses(5);
    cyc(1);
    wantFb[ch] <= 1'b0;
    pulses(2);
    wantFb[ch] <= 1'b1;
    cut_after_six();
    wantFb <= 4'h0;
    $display("short timeout test done");
    for (int t = 0; t < 2; t++)
    begin
      wantG <= 5'h08;
      cyc(5);
      @(negedge clk);
      chk("chanEnable", 7'h00, {3'h0, chanEnable});
      chk("currentScale", t == 0 ? 7'h4c : 7'h44, currentScale);
      cyc(1);
      wantG <= 5'h00;
      cyc(5);
      @(negedge clk);
      chk("chanEnable", expMask, {3'h0, chanEnable});
      cyc(1);
    end
    $display("hot test done");
    for (int k = 0; k < 3; k++)
    begin
      ch = (base + 1 + k) % 4;
      pulses(1);
      wantLow[ch] <= 1'b1;
      wantG <= k == 1 ? 5'h10 : (k == 2 ? 5'h04 : 5'h00);
      cut_after_six();
      wantLow <= 4'h0;
      wantG <= 5'h00;
    end
    $display("open timeout test done");
    wantG <= 5'h02;
    cyc(5);
    @(negedge clk);
    chk("shutdownLatched", 7'h01, {6'h00, shutdownLatched});
    chk("inputSwitchOn", 7'h00, {6'h00, inputSwitchOn});
    cyc(1);
    wantG <= 5'h00;
    cyc(5);
    @(negedge clk);
    chk("shutdownLatched", 7'h01, {6'h00, shutdownLatched});
    chk("boostEnable", 7'h00, {6'h00, boostEnable});
    cyc(1);
    sys_rst <= 1'b1;
    cyc(3);
    chk_reset();
    // A short seen at start-up must only take effect once the window has run out.
    wantG <= 5'h01;
    cyc(1);
    sys_rst <= 1'b0;
    cyc(WIN / 2);
    @(negedge clk);
    chk("shutdownLatched", 7'h00, {6'h00, shutdownLatched});
    cyc(WIN);
    @(negedge clk);
    chk("shutdownLatched", 7'h01, {6'h00, shutdownLatched});
    chk("boostEnable", 7'h00, {6'h00, boostEnable});
    $display("start short test done");
    cyc(1);
    sys_rst <= 1'b1;
    wantG <= 5'h00;
    cyc(3);
    chk_reset();
    finish_test();
  end
endmodule // tb_lcfm_fault_mgr
